// >>> design/brcd_pkg.sv
// Constants, field layouts and carrier types for the burst read configuration block
`default_nettype none
package brcd_pkg;
    localparam int BRCD_ADDR_W = 22;
    localparam int BRCD_PIN_W = BRCD_ADDR_W + 2;

    // Register byte offsets
    localparam logic [7:0] BRCD_CFG_OFF = 8'h00;
    localparam logic [7:0] BRCD_STATUS_OFF = 8'h04;
    localparam logic [7:0] BRCD_WADDR_OFF = 8'h08;

    // Status field positions
    localparam int BRCD_ST_ACTIVE_BIT = 0;
    localparam int BRCD_ST_READY_BIT = 1;
    localparam int BRCD_ST_SYNC_BIT = 2;

    // Burst length codes
    localparam logic [1:0] BRCD_BL_CONT = 2'h0;
    localparam logic [1:0] BRCD_BL_8 = 2'h1;
    localparam logic [1:0] BRCD_BL_16 = 2'h2;
    localparam logic [1:0] BRCD_BL_32 = 2'h3;

    // Wait-state decode
    localparam logic [2:0] BRCD_WS_MAX_CODE = 3'h5;
    localparam logic [3:0] BRCD_WS_EDGE_OFFSET = 4'h2;

    typedef struct packed {
        logic read_mode_select_bit;
        logic ready_timing_bit;
        logic clock_edge_select_bit;
        logic [1:0] burst_length;
        logic [2:0] wait_state;
    } brcd_cfg_t;

    // Async mode, ready with data, rising edge, continuous, wait code 5
    localparam logic [7:0] BRCD_CFG_RESET = 8'he5;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } brcd_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } brcd_apb_rsp_t;

    typedef enum logic [1:0] {
        BRCD_IDLE,
        BRCD_LATENCY,
        BRCD_BURST
    } brcd_state_t;
endpackage : brcd_pkg
`default_nettype wire

// >>> design/brcd_sync.sv
// Two-stage synchroniser for pins from outside the ref_clk domain
`default_nettype none
module brcd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] q_d;

    always_comb begin
        meta_d = d;
        q_d = meta_q;
    end

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= meta_d;
            q <= q_d;
        end
    end
endmodule : brcd_sync
`default_nettype wire

// >>> design/brcd_top.sv
// Burst read configuration register and burst latency/address sequencer
`default_nettype none
module brcd_top
    import brcd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire brcd_apb_req_t apb_req,
    output brcd_apb_rsp_t apb_rsp,
    input wire logic burst_clk,
    input wire logic addr_valid_strobe_n,
    input wire logic [BRCD_ADDR_W-1:0] addr_in,
    output logic wait_ready_q,
    output logic data_strobe_q,
    output logic burst_active_q,
    output logic [BRCD_ADDR_W-1:0] word_addr_q,
    output brcd_cfg_t cfg_q
);
    // Edge number of first valid data
    function automatic logic [3:0] brcd_latency(input logic [2:0] ws);
        logic [2:0] code;
        code = (ws > BRCD_WS_MAX_CODE) ? BRCD_WS_MAX_CODE : ws;
        return {1'b0, code} + BRCD_WS_EDGE_OFFSET;
    endfunction

    // Low address bits that wrap; all ones means free-running
    function automatic logic [BRCD_ADDR_W-1:0] brcd_wrap_mask(input logic [1:0] bl);
        logic [BRCD_ADDR_W-1:0] m;
        m = '1;
        unique case (bl)
            BRCD_BL_CONT: m = '1;
            BRCD_BL_8: m = BRCD_ADDR_W'(8'h07);
            BRCD_BL_16: m = BRCD_ADDR_W'(8'h0f);
            BRCD_BL_32: m = BRCD_ADDR_W'(8'h1f);
        endcase
        return m;
    endfunction

    // Register index decode: bit 2 flags a hit
    function automatic logic [2:0] brcd_decode(input logic [7:0] a);
        logic [2:0] r;
        r = 3'h0;
        if (a == BRCD_CFG_OFF) begin
            r = 3'h4;
        end else if (a == BRCD_STATUS_OFF) begin
            r = 3'h5;
        end else if (a == BRCD_WADDR_OFF) begin
            r = 3'h6;
        end
        return r;
    endfunction

    logic [BRCD_PIN_W-1:0] pins_s;
    logic clk_s;
    logic strobe_n_s;
    logic [BRCD_ADDR_W-1:0] addr_s;

    brcd_sync #(
        .WIDTH(BRCD_PIN_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        // Strobe crosses inverted so the cleared synchroniser reads as idle
        .d({addr_in, ~addr_valid_strobe_n, burst_clk}),
        .q(pins_s)
    );

    assign clk_s = pins_s[0];
    assign strobe_n_s = ~pins_s[1];
    assign addr_s = pins_s[BRCD_PIN_W-1:2];

    // ---------------- APB slave ----------------
    logic setup_phase;
    logic access_done;
    logic [2:0] dec;
    brcd_cfg_t cfg_d;
    brcd_apb_rsp_t apb_rsp_d;
    logic [31:0] status_word;

    always_comb begin
        setup_phase = apb_req.psel & ~apb_req.penable;
        access_done = apb_req.psel & apb_req.penable & apb_rsp.pready;
        dec = brcd_decode(apb_req.paddr);
        status_word = '0;
        status_word[BRCD_ST_ACTIVE_BIT] = burst_active_q;
        status_word[BRCD_ST_READY_BIT] = wait_ready_q;
        status_word[BRCD_ST_SYNC_BIT] = ~cfg_q.read_mode_select_bit;
        cfg_d = cfg_q;
        apb_rsp_d = apb_rsp;
        apb_rsp_d.pready = setup_phase;
        // Answer is prepared in setup so every output leaves a flop
        if (setup_phase) begin
            apb_rsp_d.pslverr = ~dec[2];
            apb_rsp_d.prdata = '0;
            if (!apb_req.pwrite) begin
                unique case (dec)
                    3'h4: apb_rsp_d.prdata = {24'h000000, cfg_q};
                    3'h5: apb_rsp_d.prdata = status_word;
                    3'h6: apb_rsp_d.prdata = 32'(word_addr_q);
                    default: apb_rsp_d.prdata = '0;
                endcase
            end
        end
        // Fields take effect at once, also during a burst
        if (access_done && apb_req.pwrite && dec == 3'h4) begin
            cfg_d = brcd_cfg_t'(apb_req.pwdata[7:0]);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= brcd_cfg_t'(BRCD_CFG_RESET);
            apb_rsp <= '0;
        end else begin
            cfg_q <= cfg_d;
            apb_rsp <= apb_rsp_d;
        end
    end

    // ---------------- Burst sequencer ----------------
    brcd_state_t state_q, state_d;
    logic clk_prev_q, clk_prev_d;
    logic strobe_prev_q, strobe_prev_d;
    logic [3:0] edge_cnt_q, edge_cnt_d;
    logic [BRCD_ADDR_W-1:0] start_addr_q, start_addr_d;
    logic [BRCD_ADDR_W-1:0] word_addr_d;
    logic [BRCD_ADDR_W-1:0] mask;
    logic wait_ready_d, data_strobe_d, burst_active_d;
    logic act_edge, strobe_rise, sync_en;
    logic [3:0] lat, next_cnt;

    always_comb begin
        act_edge = cfg_q.clock_edge_select_bit ? (clk_s & ~clk_prev_q)
                                               : (~clk_s & clk_prev_q);
        strobe_rise = strobe_n_s & ~strobe_prev_q;
        sync_en = ~cfg_q.read_mode_select_bit;
        lat = brcd_latency(cfg_q.wait_state);
        mask = brcd_wrap_mask(cfg_q.burst_length);
        next_cnt = edge_cnt_q + 4'h1;
        clk_prev_d = clk_s;
        strobe_prev_d = strobe_n_s;
        state_d = state_q;
        edge_cnt_d = edge_cnt_q;
        start_addr_d = start_addr_q;
        word_addr_d = word_addr_q;
        wait_ready_d = wait_ready_q;
        data_strobe_d = 1'b0;
        if (!sync_en) begin
            // Asynchronous reads: no burst, ready held high
            state_d = BRCD_IDLE;
            wait_ready_d = 1'b1;
        end else if (!strobe_n_s) begin
            // Strobe low loads a new address and ends any burst
            state_d = BRCD_IDLE;
            start_addr_d = addr_s;
            wait_ready_d = 1'b0;
        end else begin
            unique case (state_q)
                BRCD_IDLE: begin
                    if (strobe_rise) begin
                        state_d = BRCD_LATENCY;
                        edge_cnt_d = 4'h0;
                    end
                end
                BRCD_LATENCY: begin
                    if (act_edge) begin
                        edge_cnt_d = next_cnt;
                        if (next_cnt == lat) begin
                            state_d = BRCD_BURST;
                            data_strobe_d = 1'b1;
                            word_addr_d = start_addr_q;
                            wait_ready_d = 1'b1;
                        end else if (next_cnt == lat - 4'h1 && !cfg_q.ready_timing_bit) begin
                            wait_ready_d = 1'b1;
                        end
                    end
                end
                BRCD_BURST: begin
                    if (act_edge) begin
                        data_strobe_d = 1'b1;
                        // Low bits count within the block, high bits stay
                        word_addr_d = (word_addr_q & ~mask) |
                                      ((word_addr_q + BRCD_ADDR_W'(1)) & mask);
                    end
                end
            endcase
        end
        burst_active_d = (state_d == BRCD_BURST);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= BRCD_IDLE;
            clk_prev_q <= 1'b0;
            // Idle level, so no false strobe rise after reset
            strobe_prev_q <= 1'b1;
            edge_cnt_q <= 4'h0;
            start_addr_q <= '0;
            word_addr_q <= '0;
            wait_ready_q <= 1'b1;
            data_strobe_q <= 1'b0;
            burst_active_q <= 1'b0;
        end else begin
            state_q <= state_d;
            clk_prev_q <= clk_prev_d;
            strobe_prev_q <= strobe_prev_d;
            edge_cnt_q <= edge_cnt_d;
            start_addr_q <= start_addr_d;
            word_addr_q <= word_addr_d;
            wait_ready_q <= wait_ready_d;
            data_strobe_q <= data_strobe_d;
            burst_active_q <= burst_active_d;
        end
    end
endmodule : brcd_top
`default_nettype wire

// >>> verif/brcd_properties.sv
// Port-level checks for the burst read configuration block
`default_nettype none
module brcd_props
    import brcd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire brcd_apb_req_t apb_req,
    input wire brcd_apb_rsp_t apb_rsp,
    input wire logic wait_ready_q,
    input wire logic data_strobe_q,
    input wire logic burst_active_q,
    input wire logic [BRCD_ADDR_W-1:0] word_addr_q,
    input wire brcd_cfg_t cfg_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic [BRCD_ADDR_W-1:0] prev_q;
    logic more_q;
    wire sync = !cfg_q.read_mode_select_bit;
    wire setup = apb_req.psel && !apb_req.penable;
    wire wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
    // Continuous mode wraps only at the full address width
    wire [BRCD_ADDR_W-1:0] mask = (cfg_q.burst_length == BRCD_BL_CONT) ? '1 :
        BRCD_ADDR_W'((4 << cfg_q.burst_length) - 1);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prev_q <= '0;
            more_q <= 1'b0;
        end else if (data_strobe_q) begin
            prev_q <= word_addr_q;
            more_q <= 1'b1;
        end else if (!burst_active_q) begin
            more_q <= 1'b0;
        end
    end
    AST_CFG_RESET: assert property ($rose(rstn) |-> cfg_q == BRCD_CFG_RESET && wait_ready_q)
        else $error("config not at default after reset");
    AST_PREADY: assert property (setup |=> apb_rsp.pready)
        else $error("no zero wait answer");
    AST_CFG_WRITE: assert property (wr && apb_req.paddr == BRCD_CFG_OFF
        |=> cfg_q == 8'($past(apb_req.pwdata))) else $error("config write lost");
    AST_UNMAPPED: assert property (setup && apb_req.paddr > BRCD_WADDR_OFF
        |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped not refused");
    AST_ASYNC: assert property (cfg_q.read_mode_select_bit [*3] |-> wait_ready_q && !data_strobe_q)
        else $error("burst activity in async mode");
    AST_DATA_READY: assert property (data_strobe_q |-> wait_ready_q && burst_active_q)
        else $error("data without ready");
    AST_PULSE: assert property (data_strobe_q |=> !data_strobe_q)
        else $error("data strobe longer than one cycle");
    AST_EARLY: assert property (sync && !cfg_q.ready_timing_bit && $rose(wait_ready_q)
        |-> !data_strobe_q [*8]) else $error("early ready came with data");
    AST_WITH: assert property (sync && cfg_q.ready_timing_bit && $rose(wait_ready_q)
        |-> data_strobe_q) else $error("ready not with data");
    AST_WRAP: assert property (more_q && data_strobe_q && sync
        |-> word_addr_q == ((prev_q & ~mask) | ((prev_q + 22'h1) & mask)))
        else $error("wrong next word address");
endmodule // brcd_props
bind brcd_top brcd_props u_props (.ref_clk, .rstn, .apb_req, .apb_rsp, .wait_ready_q,
    .data_strobe_q, .burst_active_q, .word_addr_q, .cfg_q);
`default_nettype wire

// >>> verif/brcd_host.sv
// Host controller model: burst clock, address strobe and word address
`default_nettype none
module brcd_host
    import brcd_pkg::*;
(
    input wire logic ref_clk,
    output logic burst_clk,
    output logic addr_valid_strobe_n,
    output logic [BRCD_ADDR_W-1:0] addr_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        burst_clk = 1'b0;
        addr_valid_strobe_n = 1'b1;
        addr_in = '0;
    end
    // Clock stands low between frames; released address shows its inverse
    task automatic burst(input logic [BRCD_ADDR_W-1:0] a, input int n);
        @(posedge ref_clk);
        addr_valid_strobe_n <= 1'b0;
        addr_in <= a;
        repeat (6) @(posedge ref_clk);
        addr_valid_strobe_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        addr_in <= ~a;
        repeat (6) @(posedge ref_clk);
        // 16 ref_clk cycles make the 80 ns burst clock
        repeat (n) begin
            burst_clk <= 1'b1;
            repeat (8) @(posedge ref_clk);
            burst_clk <= 1'b0;
            repeat (8) @(posedge ref_clk);
        end
    endtask
endmodule // brcd_host
`default_nettype wire

// >>> verif/burst_read_config_decode_test.sv
// Self-checking bench for the burst read configuration block
`default_nettype none
module burst_read_config_decode_test;
    timeunit 1ns;
    timeprecision 100ps;
    import brcd_pkg::*;
    logic ref_clk, rstn, burst_clk, strobe_n, ready, dstb, active, rdy_prev, rdy_low, err;
    brcd_apb_req_t req;
    brcd_apb_rsp_t rsp;
    brcd_cfg_t cfg;
    logic [BRCD_ADDR_W-1:0] addr_in, waddr;
    logic [BRCD_ADDR_W-1:0] seen[$];
    logic [31:0] rd;
    int errors, tests_run, edges, data_cnt, rdy_cnt;
    brcd_top dut (.ref_clk(ref_clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp),
        .burst_clk(burst_clk), .addr_valid_strobe_n(strobe_n), .addr_in(addr_in),
        .wait_ready_q(ready), .data_strobe_q(dstb), .burst_active_q(active),
        .word_addr_q(waddr), .cfg_q(cfg));
    brcd_host host (.ref_clk(ref_clk), .burst_clk(burst_clk), .addr_valid_strobe_n(strobe_n),
        .addr_in(addr_in));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge burst_clk) if (cfg.clock_edge_select_bit === 1'b1) edges++;
    always @(negedge burst_clk) if (cfg.clock_edge_select_bit === 1'b0) edges++;
    always @(negedge strobe_n) begin
        edges = 0;
        data_cnt = -1;
        rdy_cnt = -1;
        seen.delete();
    end
    // Outputs are registered, so mid-cycle sampling avoids edge races
    always @(negedge ref_clk) begin
        if (dstb === 1'b1) begin
            if (seen.size() == 0) data_cnt = edges;
            seen.push_back(waddr);
        end
        if (ready === 1'b1 && rdy_prev !== 1'b1) rdy_cnt = edges;
        if (ready !== 1'b1) rdy_low = 1'b1;
        rdy_prev = ready;
    end
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        n = 0;
        // Values read right at the edge are those the slave presented there
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        check(n < 50, "no pready");
    endtask
    task automatic burst(input brcd_cfg_t c, input logic [21:0] a, input int n);
        apb(1'b1, BRCD_CFG_OFF, {24'h0, c});
        rdy_low = 1'b0;
        host.burst(a, n);
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic t_reset;
        apb(1'b0, BRCD_CFG_OFF, 32'h0);
        check(rd === {24'h0, BRCD_CFG_RESET} && cfg === BRCD_CFG_RESET, "reset cfg");
        check(cfg.read_mode_select_bit === 1'b1 && cfg.ready_timing_bit === 1'b1 && cfg.clock_edge_select_bit === 1'b1 && cfg.burst_length === 2'h0 && cfg.wait_state === 3'h5, "reset fields");
        apb(1'b0, BRCD_STATUS_OFF, 32'h0);
        check(rd === 32'h2 && err === 1'b0, "reset status");
    endtask
    task automatic t_regs;
        apb(1'b0, 8'h0c, 32'h0);
        check(err === 1'b1 && rd === 32'h0, "unmapped read");
        apb(1'b1, BRCD_STATUS_OFF, 32'hff);
        @(negedge ref_clk);
        check(err === 1'b0 && cfg === BRCD_CFG_RESET, "read-only write");
        apb(1'b1, 8'h10, 32'h12);
        @(negedge ref_clk);
        check(err === 1'b1 && cfg === BRCD_CFG_RESET, "unmapped write");
    endtask
    task automatic t_async;
        burst(BRCD_CFG_RESET, 22'h155, 8);
        check(seen.size() == 0 && rdy_low === 1'b0, "async burst");
        check(active === 1'b0, "async active");
    endtask
    task automatic t_latency;
        brcd_cfg_t c;
        for (int i = 0; i < 12; i++) begin
            c = '{1'b0, i[0], i[1], BRCD_BL_CONT, 3'(i % 6)};
            burst(c, 22'(22'h100 + i), 5 + i % 6);
            check(data_cnt == c.wait_state + 2, "first data edge");
            check(rdy_cnt + !c.ready_timing_bit == c.wait_state + 2, "ready edge");
            check(seen.size() == 4 && seen[0] === 22'(22'h100 + i), "burst words");
            check(active === 1'b1, "burst active");
        end
    endtask
    task automatic t_wrap;
        logic [21:0] m;
        for (int b = 0; b < 4; b++) begin
            m = (b == 0) ? '1 : 22'((4 << b) - 1);
            burst('{1'b0, 1'b1, 1'b1, 2'(b), 3'h0}, 22'h3ffffe, 6);
            for (int k = 0; k < 4; k++)
                check(seen[k] === ((22'h3ffffe & ~m) | ((22'h3ffffe + 22'(k)) & m)), "wrap");
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        req = '0;
        rstn = 1'b0;
        rdy_prev = 1'b0;
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_reset();
        t_regs();
        t_async();
        t_latency();
        t_wrap();
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_reset();
        stop_test();
    end
    initial begin
        #100000;
        errors++;
        stop_test();
    end
endmodule // burst_read_config_decode_test
`default_nettype wire
